/* File: bscan_pkg.sv */
// shared constants for the boundary-scan cell chain and its pin map
package bscan_pkg;

  // chain geometry: one logic-state cell and one direction cell per scanned pin
  localparam int CELL_COUNT     = 200;
  localparam int PIN_COUNT      = CELL_COUNT / 2;
  localparam int LOGIC_CELL_OFS = 0;
  localparam int DIR_CELL_OFS   = 1;
  localparam int SYNC_STAGES    = 2;

  // direction-cell encoding: one means the pin listens, zero means it drives
  localparam logic DIR_INPUT  = 1'h1;
  localparam logic DIR_OUTPUT = 1'h0;

  // values after reset: every pin a listener, driving low if ever enabled
  localparam logic UPD_LEVEL_RST = 1'h0;
  localparam logic UPD_DIR_RST   = DIR_INPUT;
  localparam logic CHAIN_RST     = 1'h0;
  localparam logic TDO_RST       = 1'h0;

  // pad index of each pin whose cells are known; pad p owns cells 2p and 2p+1
  localparam int PIN_EXT_DATA_31        = 0;
  localparam int PIN_EXT_ADDR_12        = 1;
  localparam int PIN_EXT_ADDR_13        = 2;
  localparam int PIN_EXT_ADDR_14        = 3;
  localparam int PIN_EXT_ADDR_15        = 4;
  localparam int PIN_EXT_ADDR_16        = 5;
  localparam int PIN_EXT_ADDR_17        = 6;
  localparam int PIN_CLOCK_OUT          = 7;
  localparam int PIN_EXT_ADDR_18        = 8;
  localparam int PIN_EXT_ADDR_19        = 9;
  localparam int PIN_RESET_OUT          = 10;
  localparam int PIN_EXT_ADDR_20        = 11;
  localparam int PIN_RESET_IN           = 12;
  localparam int PIN_EXT_ADDR_21        = 13;
  localparam int PIN_EXT_ADDR_22        = 14;
  localparam int PIN_TRANSFER_ERROR     = 15;
  localparam int PIN_BYTE_ENABLE_0      = 16;
  localparam int PIN_BYTE_ENABLE_1      = 17;
  localparam int PIN_TRANSFER_ACK       = 18;
  localparam int PIN_BYTE_ENABLE_2      = 19;
  localparam int PIN_SHOW_CYCLE_STROBE  = 20;
  localparam int PIN_BYTE_ENABLE_3      = 21;
  localparam int PIN_READ_OUTPUT_ENABLE = 22;
  localparam int PIN_SPI_SS             = 23;
  localparam int PIN_SPI_SCK            = 24;
  localparam int PIN_SPI_MISO           = 25;
  localparam int PIN_SPI_MOSI           = 26;
  localparam int PIN_EDGE_IRQ_7         = 27;
  localparam int PIN_EDGE_IRQ_6         = 28;
  localparam int PIN_CHIP_SEL_0         = 29;
  localparam int PIN_CHIP_SEL_1         = 30;
  localparam int PIN_EDGE_IRQ_5         = 31;
  localparam int PIN_CHIP_SEL_2         = 32;
  localparam int PIN_EDGE_IRQ_4         = 33;
  localparam int PIN_CHIP_SEL_3         = 34;
  localparam int PIN_TIMER_CHAN_0       = 35;
  localparam int PIN_EDGE_IRQ_3         = 36;
  localparam int PIN_TIMER_CHAN_1       = 37;
  localparam int PIN_EDGE_IRQ_2         = 38;
  localparam int PIN_EDGE_IRQ_1         = 39;
  localparam int PIN_EDGE_IRQ_0         = 40;
  localparam int PIN_SERIAL1_IN         = 41;
  localparam int PIN_SERIAL1_OUT        = 42;
  localparam int PIN_SERIAL2_IN         = 43;
  localparam int PIN_TIMER_CHAN_2       = 44;
  localparam int PIN_SERIAL2_OUT        = 45;
  localparam int PIN_EMULATION_CS_0     = 46;

endpackage

/* File: sync_bits.sv */
// two-flop level synchroniser for a group of independent bits
module sync_bits #(
  parameter int WIDTH = 1
) (
  // destination clock
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels from another domain
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second; bits are not coherent with each other
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* File: bscan_pin_driver.sv */
// system-clock pad driver: chooses core or held update cells for each pad
module bscan_pin_driver
  import bscan_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  // system clock
  input  wire logic            clk,
  input  wire logic            rst_n,
  // mode levels and update event from the test-clock side
  input  wire logic            test_drive_async,
  input  wire logic            highz_async,
  input  wire logic            upd_toggle_async,
  input  wire logic [PINS-1:0] upd_level,
  input  wire logic [PINS-1:0] upd_dir,
  // functional core side
  input  wire logic [PINS-1:0] core_out,
  input  wire logic [PINS-1:0] core_oe,
  // pads
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe,
  output logic                 test_active
);

  logic [2:0]      ctl_sync;
  logic            toggle_seen_r;
  logic [PINS-1:0] held_level_r;
  logic [PINS-1:0] held_dir_r;
  logic            test_drive;
  logic            highz;
  logic            upd_event;
  logic [PINS-1:0] held_level;

  sync_bits #(
    .WIDTH (3)
  ) u_ctl_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({test_drive_async, highz_async, upd_toggle_async}),
    .q     (ctl_sync)
  );

  assign test_drive = ctl_sync[2];
  assign highz      = ctl_sync[1];
  assign upd_event  = ctl_sync[0] ^ toggle_seen_r;
  // level cells drive non-inverted
  assign held_level = held_level_r;

  // copy update cells only on a fresh update; they stay still for several test clocks after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_seen_r <= 1'h0;
      held_level_r  <= {PINS{UPD_LEVEL_RST}};
      held_dir_r    <= {PINS{UPD_DIR_RST}};
    end else begin
      toggle_seen_r <= ctl_sync[0];
      if (upd_event) begin
        held_level_r <= upd_level;
        held_dir_r   <= upd_dir;
      end
    end
  end

  // pad mux: highz beats test drive, which beats the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out     <= '0;
      pad_oe      <= '0;
      test_active <= 1'h0;
    end else begin
      test_active <= test_drive | highz;
      if (highz) begin
        pad_out <= '0;
        pad_oe  <= '0;
      end else if (test_drive) begin
        pad_out <= held_level;
        pad_oe  <= ~held_dir_r;
      end else begin
        pad_out <= core_out;
        pad_oe  <= core_oe;
      end
    end
  end

endmodule

/* File: boundary_scan_cell_chain.sv */
// boundary-scan cell chain: capture, shift and update of the pad cells
module boundary_scan_cell_chain
  import bscan_pkg::*;
#(
  parameter int CELLS = CELL_COUNT,
  parameter int PINS  = PIN_COUNT
) (
  // system clock
  input  wire logic            clk,
  input  wire logic            rst_n,
  // test clock and serial link
  input  wire logic            tclk,
  input  wire logic            trst_n,
  input  wire logic            tdi,
  output logic                 tdo,
  output logic                 tdo_oe,
  // controller state and instruction decode, test-clock domain
  input  wire logic            capture_dr,
  input  wire logic            shift_dr,
  input  wire logic            update_dr,
  input  wire logic            instr_extest,
  input  wire logic            instr_sample,
  input  wire logic            instr_clamp,
  input  wire logic            instr_highz,
  // functional core side, system-clock domain
  input  wire logic [PINS-1:0] core_out,
  input  wire logic [PINS-1:0] core_oe,
  output logic      [PINS-1:0] core_in,
  // scanned pads only
  input  wire logic [PINS-1:0] pad_in,
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe,
  output logic                 test_active
);

  import bscan_pkg::*;

  // cell map, cell 0 next to tdo; even cells hold levels, odd cells directions
  //   cell  0 ext_data_31 level
  //   cell  1 ext_data_31 direction
  //   cell  2 ext_addr_12 level
  //   cell  3 ext_addr_12 direction
  //   cell  4 ext_addr_13 level
  //   cell  5 ext_addr_13 direction
  //   cell  6 ext_addr_14 level
  //   cell  7 ext_addr_14 direction
  //   cell  8 ext_addr_15 level
  //   cell  9 ext_addr_15 direction
  //   cell 10 ext_addr_16 level
  //   cell 11 ext_addr_16 direction
  //   cell 12 ext_addr_17 level
  //   cell 13 ext_addr_17 direction
  //   cell 14 clock_out level
  //   cell 15 clock_out direction
  //   cell 16 ext_addr_18 level
  //   cell 17 ext_addr_18 direction
  //   cell 18 ext_addr_19 level
  //   cell 19 ext_addr_19 direction
  //   cell 20 reset_out level
  //   cell 21 reset_out direction
  //   cell 22 ext_addr_20 level
  //   cell 23 ext_addr_20 direction
  //   cell 24 reset_in level
  //   cell 25 reset_in direction
  //   cell 26 ext_addr_21 level
  //   cell 27 ext_addr_21 direction
  //   cell 28 ext_addr_22 level
  //   cell 29 ext_addr_22 direction
  //   cell 30 transfer_error level
  //   cell 31 transfer_error direction
  //   cell 32 byte_enable_0 level
  //   cell 33 byte_enable_0 direction
  //   cell 34 byte_enable_1 level
  //   cell 35 byte_enable_1 direction
  //   cell 36 transfer_ack level
  //   cell 37 transfer_ack direction
  //   cell 38 byte_enable_2 level
  //   cell 39 byte_enable_2 direction
  //   cell 40 show_cycle_strobe level
  //   cell 41 show_cycle_strobe direction
  //   cell 42 byte_enable_3 level
  //   cell 43 byte_enable_3 direction
  //   cell 44 read_output_enable level
  //   cell 45 read_output_enable direction
  //   cell 46 spi_ss level
  //   cell 47 spi_ss direction
  //   cell 48 spi_sck level
  //   cell 49 spi_sck direction
  //   cell 50 spi_miso level
  //   cell 51 spi_miso direction
  //   cell 52 spi_mosi level
  //   cell 53 spi_mosi direction
  //   cell 54 edge_irq_7 level
  //   cell 55 edge_irq_7 direction
  //   cell 56 edge_irq_6 level
  //   cell 57 edge_irq_6 direction
  //   cell 58 chip_sel_0 level
  //   cell 59 chip_sel_0 direction
  //   cell 60 chip_sel_1 level
  //   cell 61 chip_sel_1 direction
  //   cell 62 edge_irq_5 level
  //   cell 63 edge_irq_5 direction
  //   cell 64 chip_sel_2 level
  //   cell 65 chip_sel_2 direction
  //   cell 66 edge_irq_4 level
  //   cell 67 edge_irq_4 direction
  //   cell 68 chip_sel_3 level
  //   cell 69 chip_sel_3 direction
  //   cell 70 timer_chan_0 level
  //   cell 71 timer_chan_0 direction
  //   cell 72 edge_irq_3 level
  //   cell 73 edge_irq_3 direction
  //   cell 74 timer_chan_1 level
  //   cell 75 timer_chan_1 direction
  //   cell 76 edge_irq_2 level
  //   cell 77 edge_irq_2 direction
  //   cell 78 edge_irq_1 level
  //   cell 79 edge_irq_1 direction
  //   cell 80 edge_irq_0 level
  //   cell 81 edge_irq_0 direction
  //   cell 82 serial1_in level
  //   cell 83 serial1_in direction
  //   cell 84 serial1_out level
  //   cell 85 serial1_out direction
  //   cell 86 serial2_in level
  //   cell 87 serial2_in direction
  //   cell 88 timer_chan_2 level
  //   cell 89 timer_chan_2 direction
  //   cell 90 serial2_out level
  //   cell 91 serial2_out direction
  //   cell 92 emulation_cs_0 level
  //   cell 93 emulation_cs_0 direction
  //   cells 94 to 199 belong to pads 47 to 99 in pad order

  // chain position of a pad's cell; ofs picks the level or the direction cell
  function automatic int cell_index(input int p, input int ofs);
    return 2*p + ofs;
  endfunction

  // pad p owns cells 2p (level) and 2p+1 (direction); pads follow the package map
  function automatic logic [CELLS-1:0] pack_cells(
    input logic [PINS-1:0] level,
    input logic [PINS-1:0] dir
  );
    logic [CELLS-1:0] cells;
    cells = '0;
    for (int p = 0; p < PINS; p++) begin
      cells[cell_index(p, LOGIC_CELL_OFS)] = level[p];
      cells[cell_index(p, DIR_CELL_OFS)]   = dir[p];
    end
    return cells;
  endfunction

  // pull either the level or the direction cells back out of a chain image
  function automatic logic [PINS-1:0] cell_field(
    input logic [CELLS-1:0] cells,
    input int               ofs
  );
    logic [PINS-1:0] field;
    field = '0;
    for (int p = 0; p < PINS; p++) begin
      field[p] = cells[cell_index(p, ofs)];
    end
    return field;
  endfunction

  // after test reset the chain reads all zero and every update cell makes its
  // pad a listener that would drive low, so extest before any preload is safe;
  // the two resets are independent: system reset leaves the chain alone
  logic [CELLS-1:0] chain_r;
  logic [PINS-1:0]  upd_level_r;
  logic [PINS-1:0]  upd_dir_r;
  logic             upd_toggle_r;
  logic             tdo_r;
  logic             tdo_oe_r;
  logic [PINS-1:0]  pad_in_t;
  logic [PINS-1:0]  core_out_t;
  logic [PINS-1:0]  core_oe_t;
  logic             chain_sel;
  logic             test_drive;
  logic [PINS-1:0]  capture_level;
  logic [PINS-1:0]  capture_dir;

  // chain is in the serial path only for these two instructions
  assign chain_sel  = instr_extest | instr_sample;
  assign test_drive = instr_extest | instr_clamp;

  // domain crossings, each through two flops before any logic reads it:
  //   pads and core drive into the test clock, for capture only
  //   pads into the system clock, for the core's own inputs
  //   mode levels and the update toggle into the system clock, in the driver
  // the update cells cross without flops: the driver copies them only after
  // the toggle has passed its synchroniser, by which time they have stood
  // still for at least two system clocks
  // limitation: a second update within three system clocks can be missed,
  // which no legal controller walk produces at these clock rates
  // captured values are about two test clocks old; the tester must allow it
  // pads and core drive are asynchronous to the test clock: two flops each
  sync_bits #(
    .WIDTH (3 * PINS)
  ) u_tclk_sync (
    .clk   (tclk),
    .rst_n (trst_n),
    .d     ({pad_in, core_out, core_oe}),
    .q     ({pad_in_t, core_out_t, core_oe_t})
  );

  // core sees the pads through its own synchroniser
  sync_bits #(
    .WIDTH (PINS)
  ) u_core_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pad_in),
    .q     (core_in)
  );

  // sample takes what the core drives on driven pads and the pad level on the rest; extest takes the pad
  always_comb begin
    capture_level = '0;
    capture_dir   = '0;
    for (int p = 0; p < PINS; p++) begin
      if (instr_sample && core_oe_t[p]) begin
        capture_level[p] = core_out_t[p];
      end else begin
        capture_level[p] = pad_in_t[p];
      end
      capture_dir[p] = core_oe_t[p] ? DIR_OUTPUT : DIR_INPUT;
    end
  end

  // capture and shift stage on the rising test clock
  always_ff @(posedge tclk or negedge trst_n) begin
    if (!trst_n) begin
      chain_r <= {CELLS{CHAIN_RST}};
    end else if (chain_sel && capture_dr) begin
      chain_r <= pack_cells(capture_level, capture_dir);
    end else if (chain_sel && shift_dr) begin
      chain_r <= {tdi, chain_r[CELLS-1:1]};
    end
  end

  // update cells load on the falling edge and hold between updates
  always_ff @(negedge tclk or negedge trst_n) begin
    if (!trst_n) begin
      upd_level_r  <= {PINS{UPD_LEVEL_RST}};
      upd_dir_r    <= {PINS{UPD_DIR_RST}};
      upd_toggle_r <= 1'h0;
    end else if (chain_sel && update_dr) begin
      upd_level_r  <= cell_field(chain_r, LOGIC_CELL_OFS);
      upd_dir_r    <= cell_field(chain_r, DIR_CELL_OFS);
      upd_toggle_r <= ~upd_toggle_r;
    end
  end

  // serial output changes on the falling edge so the tester samples a settled bit
  always_ff @(negedge tclk or negedge trst_n) begin
    if (!trst_n) begin
      tdo_r    <= TDO_RST;
      tdo_oe_r <= 1'h0;
    end else begin
      tdo_r    <= chain_r[0];
      tdo_oe_r <= chain_sel & shift_dr;
    end
  end

  assign tdo    = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // only the scanned pads reach the driver; test, analog and supply pins never do
  bscan_pin_driver #(
    .PINS (PINS)
  ) u_driver (
    .clk              (clk),
    .rst_n            (rst_n),
    .test_drive_async (test_drive),
    .highz_async      (instr_highz),
    .upd_toggle_async (upd_toggle_r),
    .upd_level        (upd_level_r),
    .upd_dir          (upd_dir_r),
    .core_out         (core_out),
    .core_oe          (core_oe),
    .pad_out          (pad_out),
    .pad_oe           (pad_oe),
    .test_active      (test_active)
  );

endmodule

/* File: bscan_chain_monitor.sv */
// port-level assertions for the boundary-scan cell chain
module bscan_chain_monitor
  import bscan_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  // clocks and resets
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            tclk,
  input wire logic            trst_n,
  // link and controller levels
  input wire logic            tdo,
  input wire logic            tdo_oe,
  input wire logic            shift_dr,
  input wire logic            instr_extest,
  input wire logic            instr_sample,
  input wire logic            instr_clamp,
  input wire logic            instr_highz,
  // core and pads
  input wire logic [PINS-1:0] core_out,
  input wire logic [PINS-1:0] core_oe,
  input wire logic [PINS-1:0] core_in,
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic            test_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // six cycles leave room for the three-flop mode crossing
  wire sel  = instr_extest | instr_sample;
  wire idle = !(instr_extest | instr_clamp | instr_highz);
  test_on_a: assert property (instr_extest [*6] |-> test_active)
    else $error("test mode not taken over by the pads");
  test_off_a: assert property (idle [*6] |-> !test_active)
    else $error("test mode held without a test instruction");
  highz_off_a: assert property (instr_highz [*6] |-> pad_oe == '0)
    else $error("pad driven while all drivers are off");
  func_pass_a: assert property (idle [*6] |=> pad_out == $past(core_out) && pad_oe == $past(core_oe))
    else $error("pads do not follow the core");
  core_sync_a: assert property ($past(rst_n) && $past(rst_n, 2) |-> core_in == $past(pad_in, 2))
    else $error("core input not the pad level two cycles back");
  oe_on_a: assert property (@(posedge tclk) disable iff (!trst_n) shift_dr && sel |=> tdo_oe)
    else $error("serial output not enabled while shifting");
  oe_off_a: assert property (@(posedge tclk) disable iff (!trst_n) !(shift_dr && sel) |=> !tdo_oe)
    else $error("serial output enabled outside a shift");
  refuse_a: assert property (@(posedge tclk) disable iff (!trst_n) !sel |=> $stable(tdo))
    else $error("chain moved while not selected");
  cover property (instr_extest && test_active);
  cover property (instr_highz && test_active);
  cover property (@(posedge tclk) shift_dr && sel);
endmodule

bind boundary_scan_cell_chain bscan_chain_monitor #(.PINS(PINS)) mon (
  .clk(clk), .rst_n(rst_n), .tclk(tclk), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
  .shift_dr(shift_dr), .instr_extest(instr_extest), .instr_sample(instr_sample),
  .instr_clamp(instr_clamp), .instr_highz(instr_highz), .core_out(core_out),
  .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out),
  .pad_oe(pad_oe), .test_active(test_active)
);

/* File: scan_tester.sv */
// board tester model: test clock, controller state levels and instruction levels
module scan_tester
  import bscan_pkg::*;
(
  // serial link
  output logic      tclk,
  output logic      trst_n,
  output logic      tdi,
  input  wire logic tdo,
  // controller state and instruction levels
  output logic      capture_dr,
  output logic      shift_dr,
  output logic      update_dr,
  output logic      instr_extest,
  output logic      instr_sample,
  output logic      instr_clamp,
  output logic      instr_highz
);
  timeunit 1ns;
  timeprecision 1ps;
  // board straps the tester holds for a compliant scan; no port reaches them
  localparam logic MODE_SEL_LEVEL   = 1'h0;
  localparam logic COMPLIANCE_LEVEL = 1'h1;
  // idle link: clock low, data line at its pull-up level
  initial begin
    {tclk, trst_n, tdi, capture_dr, shift_dr, update_dr} = 6'h08;
    {instr_extest, instr_sample, instr_clamp, instr_highz} = 4'h0;
  end
  // one 12 ns test-clock cycle; signals move 1 ns after the falling edge
  task automatic cycle(input logic c, input logic s, input logic u, input logic d);
    {capture_dr, shift_dr, update_dr} = {c, s, u};
    tdi = s ? d : 1'h1;
    #5 tclk = 1'h1;
    #6 tclk = 1'h0;
    #1;
  endtask
  task automatic link_reset();
    trst_n = 1'h0;
    cycle(1'h0, 1'h0, 1'h0, 1'h0);
    trst_n = 1'h1;
  endtask
  // instruction order: extest, sample, clamp, highz; changed only while the clock stands
  task automatic set_mode(input logic [3:0] m);
    {instr_extest, instr_sample, instr_clamp, instr_highz} = m;
  endtask
  // one frame: settle, optional capture, full shift with cell 0 first, optional update
  task automatic scan(input logic cap, input logic upd, input logic [CELL_COUNT-1:0] din,
                      output logic [CELL_COUNT-1:0] dout);
    repeat (3) cycle(1'h0, 1'h0, 1'h0, 1'h0);
    if (cap) cycle(1'h1, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < CELL_COUNT; i++) begin
      dout[i] = tdo;
      cycle(1'h0, 1'h1, 1'h0, din[i]);
    end
    if (upd) cycle(1'h0, 1'h0, 1'h1, 1'h0);
    {capture_dr, shift_dr, update_dr, tdi} = 4'h1;
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the boundary-scan cell chain
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bscan_pkg::*;
  logic                  clk, rst_n, tclk, trst_n, tdi, tdo, tdo_oe, test_active;
  logic                  capture_dr, shift_dr, update_dr, ext, smp, clp, hiz;
  logic [PIN_COUNT-1:0]  core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  logic [CELL_COUNT-1:0] got, v, w;
  int                    err_total, samples_checked;
  boundary_scan_cell_chain dut (
    .clk(clk), .rst_n(rst_n), .tclk(tclk), .trst_n(trst_n), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr),
    .instr_extest(ext), .instr_sample(smp), .instr_clamp(clp), .instr_highz(hiz),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .test_active(test_active)
  );
  scan_tester tst (
    .tclk(tclk), .trst_n(trst_n), .tdi(tdi), .tdo(tdo), .capture_dr(capture_dr),
    .shift_dr(shift_dr), .update_dr(update_dr), .instr_extest(ext), .instr_sample(smp),
    .instr_clamp(clp), .instr_highz(hiz)
  );
  // wide enough for the idle compare of pads, core inputs and mode flag
  task automatic check(input logic [319:0] g, input logic [319:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // cell field of every pad: offset 0 level, offset 1 direction
  function automatic logic [PIN_COUNT-1:0] fld(input logic [CELL_COUNT-1:0] x, input int o);
    for (int p = 0; p < PIN_COUNT; p++) fld[p] = x[2*p+o];
  endfunction
  // capture image: sample reads core drive on driven pads, otherwise the pad level
  function automatic logic [CELL_COUNT-1:0] cap_exp(input logic s);
    for (int p = 0; p < PIN_COUNT; p++) begin
      cap_exp[2*p]   = (s && core_oe[p]) ? core_out[p] : pad_in[p];
      cap_exp[2*p+1] = ~core_oe[p];
    end
  endfunction
  task automatic settle();
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_sample();
    tst.set_mode(4'h4);
    tst.scan(1'h1, 1'h1, v, got);
    check(got, cap_exp(1'h1));
    tst.scan(1'h0, 1'h0, w, got);
    check(got, v);
  endtask
  task automatic t_extest();
    tst.set_mode(4'h8);
    settle();
    check({pad_out, pad_oe}, {fld(v, 0), ~fld(v, 1)});
    tst.scan(1'h1, 1'h0, w, got);
    check(got, cap_exp(1'h0));
    settle();
    check({pad_out, pad_oe}, {fld(v, 0), ~fld(v, 1)});
    tst.scan(1'h0, 1'h1, w, got);
    check(got, w);
    settle();
    check({pad_out, pad_oe}, {fld(w, 0), ~fld(w, 1)});
    check({pad_out[PIN_EXT_DATA_31], pad_oe[PIN_EXT_DATA_31]}, {w[0], ~w[1]});
    check({pad_out[PIN_EMULATION_CS_0], pad_oe[PIN_EMULATION_CS_0]}, {w[92], ~w[93]});
  endtask
  task automatic t_hold_modes();
    tst.set_mode(4'h2);
    tst.scan(1'h1, 1'h1, v, got);
    check(got, {CELL_COUNT{w[0]}});
    settle();
    check({pad_out, pad_oe}, {fld(w, 0), ~fld(w, 1)});
    tst.set_mode(4'h1);
    settle();
    check(pad_oe, '0);
  endtask
  task automatic t_idle();
    tst.set_mode(4'h0);
    @(negedge clk);
    core_out = ~core_out;
    pad_in   = ~pad_in;
    settle();
    check({pad_out, pad_oe, core_in, test_active}, {core_out, core_oe, pad_in, 1'h0});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // system clock, 100 MHz
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // a hung handshake would stall far past the five frames of the run
  initial begin
    #300000;
    err_total++;
    close_out();
  end
  // main sequence; the mixed patterns give driven and listening pads side by side
  initial begin
    {rst_n, err_total, samples_checked} = '0;
    {pad_in, core_oe, core_out} = {{25{4'h5}}, {25{4'h3}}, {25{4'hA}}};
    v = {50{4'h9}};
    w = {25{8'h3C}};
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    tst.link_reset();
    check({pad_out, pad_oe, test_active, tdo, tdo_oe}, {core_out, core_oe, 3'h0});
    t_sample();
    t_extest();
    t_hold_modes();
    t_idle();
    close_out();
  end
endmodule
